// *** hdl/jfp_pkg.sv ***
// Constants for the test-port flash page programming block.
// Assumes a test access port controller outside that decodes the
// instruction and gives capture, shift and update strobes on tck.
package jfp_pkg;

   // ****************************************************************
   // Instructions (codes arbitrary, outside decoder agrees)
   // ****************************************************************
   localparam int          INSTR_W               = 4;
   localparam logic [3:0]  CORE_RESET_HOLD_INSTR = 4'hc;
   localparam logic [3:0]  PROGRAM_MODE_KEY_INSTR = 4'h4;
   localparam logic [3:0]  PROGRAM_COMMAND_INSTR = 4'h5;
   localparam logic [3:0]  PAGE_LOAD_INSTR       = 4'h6;
   localparam logic [3:0]  PAGE_READ_INSTR       = 4'h7;

   // ****************************************************************
   // Data registers
   // ****************************************************************
   localparam int          KEY_W          = 16;
   localparam logic [15:0] MODE_KEY       = 16'ha370;
   localparam int          CMD_W          = 15;
   localparam logic [6:0]  CMD_ENTER      = 7'h23;
   localparam logic [6:0]  CMD_ADDR_HI    = 7'h07;
   localparam logic [6:0]  CMD_ADDR_LO    = 7'h03;
   localparam logic [14:0] CMD_NOP_FIRST  = 15'h2300;
   localparam logic [14:0] CMD_NOP_SECOND = 15'h3300;

   // ****************************************************************
   // Page geometry and addresses
   // ****************************************************************
   localparam int          ADDR_W               = 16;
   localparam int          PAGE_IDX_W           = 8;
   localparam int          PAGE_WORD_W          = 7;
   localparam int          PROGRAM_ADDR_TOP_BIT = 15;
   localparam int          NV_DATA_ADDR_TOP_BIT = 11;
   localparam logic [2:0]  BYTE_LAST_BIT        = 3'h7;
   localparam int          PG_XFER_W            = 17;
   localparam int          RSP_W                = 16;

   // ****************************************************************
   // Values after reset
   // ****************************************************************
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [7:0]  OP_RESET   = 8'h00;
   localparam logic [7:0]  BYTE_RESET = 8'h00;

   // ****************************************************************
   // Flash fetch sequencer, one-hot
   // ****************************************************************
   typedef enum logic [1:0] {
      FETCH_IDLE = 2'b01,
      FETCH_WAIT = 2'b10
   } jfp_fetch_t;

endpackage

// *** hdl/jfp_xfer_if.sv ***
// Word crossing between the two clock domains of the block.
// Source holds data stable and flips req_tgl once per word.
`timescale 1ns/1ps
interface jfp_xfer_if #(parameter int W = 8);
   logic         req_tgl;
   logic [W-1:0] data;
   modport src (output req_tgl, output data);
   modport dst (input req_tgl, input data);
endinterface

// *** hdl/jfp_xfer_rx.sv ***
// Receiving end of a toggle crossing into the clk domain given.
// Assumes words arrive no faster than three destination cycles apart.
`timescale 1ns/1ps
module jfp_xfer_rx #(parameter int W = 8) (
   // Destination clock
   input  wire logic         clk,
   input  wire logic         rst,
   // Crossing
   jfp_xfer_if.dst           link,
   // Received word
   output logic              strobe,
   output logic [W-1:0]      data_out
);

   logic         sync1_reg;
   logic         sync2_reg;
   logic         sync3_reg;
   logic         strobe_reg;
   logic         strobe_next;
   logic [W-1:0] data_reg;
   logic [W-1:0] data_next;

   // Data is stable once the toggle has passed two stages
   always_comb begin
      strobe_next = sync2_reg ^ sync3_reg;
      data_next   = strobe_next ? link.data : data_reg;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg  <= 1'b0;
         sync2_reg  <= 1'b0;
         sync3_reg  <= 1'b0;
         strobe_reg <= 1'b0;
         data_reg   <= '0;
      end else begin
         sync1_reg  <= link.req_tgl;
         sync2_reg  <= sync1_reg;
         sync3_reg  <= sync2_reg;
         strobe_reg <= strobe_next;
         data_reg   <= data_next;
      end
   end

   assign strobe   = strobe_reg;
   assign data_out = data_reg;

endmodule

// *** hdl/jfp_prog_port.sv ***
// Test-port data registers for flash page programming: reset hold,
// mode key, command register, page load and page read chains.
// Assumes an outside tap controller on tck and flash that answers
// combinationally on clk while fl_rd is high.
//
// Functional notes
// - Address bits above the implemented top bit of each memory are ignored.
// - Page load is one chain of a page of bits, fed byte-wise to the buffer.
// - Page read is a page of bits plus eight, fed byte-wise from flash.
// - The first eight read shifts fetch byte zero and carry no data.
// - After those, read data leaves from first word LSB to last word MSB.
// - Shifting the 16-bit key into the mode key register enters programming.
// - Shifting zeros into the mode key register leaves programming mode.
// - No-operation is two 15-bit commands; returned data is ignored.
`timescale 1ns/1ps
module jfp_prog_port (
   // System clock
   input  wire logic        clk,
   input  wire logic        rst,
   // Test port, tck domain
   input  wire logic        tck,
   input  wire logic        tdi,
   output logic             tdo,
   input  wire logic [3:0]  instr,
   input  wire logic        capture_dr,
   input  wire logic        shift_dr,
   input  wire logic        update_dr,
   // Core control, clk domain
   output logic             core_reset_hold,
   output logic             prog_mode,
   output logic [7:0]       op_code,
   output logic             ops_disabled,
   // Addresses
   output logic [15:0]      prog_addr,
   output logic [15:0]      nv_addr,
   // Page buffer write
   output logic             pb_wr,
   output logic [7:0]       pb_idx,
   output logic [7:0]       pb_wdata,
   // Flash word read
   output logic             fl_rd,
   output logic [15:0]      fl_rd_addr,
   input  wire logic [15:0] fl_rd_data
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [15:0] mask_addr(input logic [15:0] a,
                                             input int top);
      logic [15:0] m;
      m = '0;
      for (int i = 0; i < jfp_pkg::ADDR_W; i++) begin
         m[i] = (i <= top);
      end
      return a & m;
   endfunction

   // ****************************************************************
   // Crossings
   // ****************************************************************
   jfp_xfer_if #(.W(jfp_pkg::CMD_W))     cmd_x ();
   jfp_xfer_if #(.W(jfp_pkg::PG_XFER_W)) pg_x ();
   jfp_xfer_if #(.W(jfp_pkg::RSP_W))     rsp_x ();

   logic        cmd_stb;
   logic [14:0] cmd_word;
   logic        pg_stb;
   logic [16:0] pg_word;
   logic        rsp_stb;
   logic [15:0] rsp_word;

   jfp_xfer_rx #(.W(jfp_pkg::CMD_W)) u_cmd_rx (
      .clk      (clk),
      .rst      (rst),
      .link     (cmd_x),
      .strobe   (cmd_stb),
      .data_out (cmd_word)
   );

   jfp_xfer_rx #(.W(jfp_pkg::PG_XFER_W)) u_pg_rx (
      .clk      (clk),
      .rst      (rst),
      .link     (pg_x),
      .strobe   (pg_stb),
      .data_out (pg_word)
   );

   jfp_xfer_rx #(.W(jfp_pkg::RSP_W)) u_rsp_rx (
      .clk      (tck),
      .rst      (rst),
      .link     (rsp_x),
      .strobe   (rsp_stb),
      .data_out (rsp_word)
   );

   // ****************************************************************
   // Tck: reset hold, mode key and command registers
   // ****************************************************************
   logic        rst_sh_reg,  rst_sh_next;
   logic        hold_reg,    hold_next;
   logic [15:0] key_sh_reg,  key_sh_next;
   logic        mode_reg,    mode_next;
   logic [14:0] cmd_sh_reg,  cmd_sh_next;
   logic [14:0] cmd_out_reg, cmd_out_next;
   logic        cmd_tgl_reg, cmd_tgl_next;
   logic        tdo_reg,     tdo_next;
   logic [7:0]  sh_reg;

   always_comb begin
      rst_sh_next  = rst_sh_reg;
      hold_next    = hold_reg;
      key_sh_next  = key_sh_reg;
      mode_next    = mode_reg;
      cmd_sh_next  = cmd_sh_reg;
      cmd_out_next = cmd_out_reg;
      cmd_tgl_next = cmd_tgl_reg;
      case (instr)
         jfp_pkg::CORE_RESET_HOLD_INSTR: begin
            if (shift_dr) rst_sh_next = tdi;
            if (update_dr) hold_next = rst_sh_reg;
         end
         jfp_pkg::PROGRAM_MODE_KEY_INSTR: begin
            if (shift_dr) key_sh_next = {tdi, key_sh_reg[15:1]};
            if (update_dr) begin
               mode_next = (key_sh_reg == jfp_pkg::MODE_KEY);
            end
         end
         jfp_pkg::PROGRAM_COMMAND_INSTR: begin
            // Capture clears; data returned on this chain is don't care
            if (capture_dr) cmd_sh_next = '0;
            if (shift_dr) cmd_sh_next = {tdi, cmd_sh_reg[14:1]};
            if (update_dr) begin
               cmd_out_next = cmd_sh_reg;
               cmd_tgl_next = ~cmd_tgl_reg;
            end
         end
         default: begin
         end
      endcase
      case (instr)
         jfp_pkg::CORE_RESET_HOLD_INSTR:  tdo_next = rst_sh_reg;
         jfp_pkg::PROGRAM_MODE_KEY_INSTR: tdo_next = key_sh_reg[0];
         jfp_pkg::PROGRAM_COMMAND_INSTR:  tdo_next = cmd_sh_reg[0];
         jfp_pkg::PAGE_LOAD_INSTR,
         jfp_pkg::PAGE_READ_INSTR:        tdo_next = sh_reg[0];
         default:                         tdo_next = tdi;
      endcase
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         rst_sh_reg  <= 1'b0;
         hold_reg    <= 1'b0;
         key_sh_reg  <= '0;
         mode_reg    <= 1'b0;
         cmd_sh_reg  <= '0;
         cmd_out_reg <= '0;
         cmd_tgl_reg <= 1'b0;
      end else begin
         rst_sh_reg  <= rst_sh_next;
         hold_reg    <= hold_next;
         key_sh_reg  <= key_sh_next;
         mode_reg    <= mode_next;
         cmd_sh_reg  <= cmd_sh_next;
         cmd_out_reg <= cmd_out_next;
         cmd_tgl_reg <= cmd_tgl_next;
      end
   end

   // Falling edge so the programmer samples a settled bit
   always_ff @(negedge tck or posedge rst) begin
      if (rst) tdo_reg <= 1'b0;
      else     tdo_reg <= tdo_next;
   end

   assign cmd_x.req_tgl = cmd_tgl_reg;
   assign cmd_x.data    = cmd_out_reg;
   assign tdo           = tdo_reg;

   // ****************************************************************
   // Tck: page load and page read chains
   // ****************************************************************
   logic [7:0]  sh_next;
   logic [2:0]  bit_reg,    bit_next;
   logic [7:0]  idx_reg,    idx_next;
   logic        pg_tgl_reg, pg_tgl_next;
   logic [16:0] pg_out_reg, pg_out_next;
   logic [15:0] word_reg,   word_next;
   logic [7:0]  hi_reg,     hi_next;
   logic        rd_sel_reg;
   logic        rd_sel;
   logic        ask_word;
   logic [6:0]  ask_idx;

   assign rd_sel = (instr == jfp_pkg::PAGE_READ_INSTR) && mode_reg;

   always_comb begin
      sh_next     = sh_reg;
      bit_next    = bit_reg;
      idx_next    = idx_reg;
      pg_tgl_next = pg_tgl_reg;
      pg_out_next = pg_out_reg;
      word_next   = rsp_stb ? rsp_word : word_reg;
      hi_next     = hi_reg;
      ask_word    = 1'b0;
      ask_idx     = '0;
      if (capture_dr && (rd_sel ||
          (instr == jfp_pkg::PAGE_LOAD_INSTR && mode_reg))) begin
         sh_next  = '0;
         bit_next = '0;
         idx_next = '0;
      end else if (shift_dr && instr == jfp_pkg::PAGE_LOAD_INSTR
                   && mode_reg) begin
         sh_next  = {tdi, sh_reg[7:1]};
         bit_next = bit_reg + 3'h1;
         if (bit_reg == jfp_pkg::BYTE_LAST_BIT) begin
            pg_out_next = {1'b0, idx_reg, tdi, sh_reg[7:1]};
            pg_tgl_next = ~pg_tgl_reg;
            idx_next    = idx_reg + 8'h01;
         end
      end else if (shift_dr && rd_sel) begin
         sh_next  = {1'b0, sh_reg[7:1]};
         bit_next = bit_reg + 3'h1;
         // Byte zero is not on tdo until this load is done
         if (bit_reg == jfp_pkg::BYTE_LAST_BIT) begin
            idx_next = idx_reg + 8'h01;
            if (!idx_reg[0]) begin
               sh_next  = word_reg[7:0];
               hi_next  = word_reg[15:8];
               ask_word = 1'b1;
               ask_idx  = idx_reg[7:1] + 7'h01;
            end else begin
               sh_next = hi_reg;
            end
         end
      end
      // Word zero is fetched ahead, on select and after each read
      if ((rd_sel && !rd_sel_reg) || (update_dr && rd_sel)) begin
         ask_word = 1'b1;
         ask_idx  = '0;
      end
      if (ask_word) begin
         pg_out_next = {1'b1, 1'b0, ask_idx, jfp_pkg::BYTE_RESET};
         pg_tgl_next = ~pg_tgl_reg;
      end
   end

   always_ff @(posedge tck or posedge rst) begin
      if (rst) begin
         sh_reg     <= jfp_pkg::BYTE_RESET;
         bit_reg    <= '0;
         idx_reg    <= '0;
         pg_tgl_reg <= 1'b0;
         pg_out_reg <= '0;
         word_reg   <= '0;
         hi_reg     <= jfp_pkg::BYTE_RESET;
         rd_sel_reg <= 1'b0;
      end else begin
         sh_reg     <= sh_next;
         bit_reg    <= bit_next;
         idx_reg    <= idx_next;
         pg_tgl_reg <= pg_tgl_next;
         pg_out_reg <= pg_out_next;
         word_reg   <= word_next;
         hi_reg     <= hi_next;
         rd_sel_reg <= rd_sel;
      end
   end

   assign pg_x.req_tgl = pg_tgl_reg;
   assign pg_x.data    = pg_out_reg;

   // ****************************************************************
   // Clk: levels, command decode, page buffer and flash fetch
   // ****************************************************************
   logic [1:0]           lvl1_reg;
   logic [1:0]           lvl2_reg;
   logic [15:0]          addr_reg,    addr_next;
   logic [7:0]           op_reg,      op_next;
   logic                 pb_wr_reg,   pb_wr_next;
   logic [7:0]           pb_idx_reg,  pb_idx_next;
   logic [7:0]           pb_dat_reg,  pb_dat_next;
   logic                 fl_rd_reg,   fl_rd_next;
   logic [15:0]          fl_adr_reg,  fl_adr_next;
   logic                 rsp_tgl_reg, rsp_tgl_next;
   logic [15:0]          rsp_reg,     rsp_next;
   jfp_pkg::jfp_fetch_t  st_reg,      st_next;

   // Only the second stage is read beyond the synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lvl1_reg <= 2'h0;
         lvl2_reg <= 2'h0;
      end else begin
         lvl1_reg <= {mode_reg, hold_reg};
         lvl2_reg <= lvl1_reg;
      end
   end

   always_comb begin
      addr_next    = addr_reg;
      op_next      = op_reg;
      pb_wr_next   = 1'b0;
      pb_idx_next  = pb_idx_reg;
      pb_dat_next  = pb_dat_reg;
      fl_rd_next   = 1'b0;
      fl_adr_next  = fl_adr_reg;
      rsp_tgl_next = rsp_tgl_reg;
      rsp_next     = rsp_reg;
      st_next      = st_reg;
      if (!lvl2_reg[1]) begin
         op_next = jfp_pkg::OP_RESET;
      end else if (cmd_stb) begin
         case (cmd_word[14:8])
            jfp_pkg::CMD_ENTER:   op_next = cmd_word[7:0];
            jfp_pkg::CMD_ADDR_HI: addr_next[15:8] = cmd_word[7:0];
            jfp_pkg::CMD_ADDR_LO: addr_next[7:0]  = cmd_word[7:0];
            default: begin
            end
         endcase
      end
      if (pg_stb && lvl2_reg[1] && !pg_word[16]) begin
         pb_wr_next  = 1'b1;
         pb_idx_next = pg_word[15:8];
         pb_dat_next = pg_word[7:0];
      end
      case (st_reg)
         jfp_pkg::FETCH_IDLE: begin
            if (pg_stb && pg_word[16]) begin
               fl_rd_next  = 1'b1;
               fl_adr_next = {prog_addr[15:7], pg_word[14:8]};
               st_next     = jfp_pkg::FETCH_WAIT;
            end
         end
         jfp_pkg::FETCH_WAIT: begin
            rsp_next     = fl_rd_data;
            rsp_tgl_next = ~rsp_tgl_reg;
            st_next      = jfp_pkg::FETCH_IDLE;
         end
         default: st_next = jfp_pkg::FETCH_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addr_reg    <= jfp_pkg::ADDR_RESET;
         op_reg      <= jfp_pkg::OP_RESET;
         pb_wr_reg   <= 1'b0;
         pb_idx_reg  <= jfp_pkg::BYTE_RESET;
         pb_dat_reg  <= jfp_pkg::BYTE_RESET;
         fl_rd_reg   <= 1'b0;
         fl_adr_reg  <= jfp_pkg::ADDR_RESET;
         rsp_tgl_reg <= 1'b0;
         rsp_reg     <= '0;
         st_reg      <= jfp_pkg::FETCH_IDLE;
      end else begin
         addr_reg    <= addr_next;
         op_reg      <= op_next;
         pb_wr_reg   <= pb_wr_next;
         pb_idx_reg  <= pb_idx_next;
         pb_dat_reg  <= pb_dat_next;
         fl_rd_reg   <= fl_rd_next;
         fl_adr_reg  <= fl_adr_next;
         rsp_tgl_reg <= rsp_tgl_next;
         rsp_reg     <= rsp_next;
         st_reg      <= st_next;
      end
   end

   assign rsp_x.req_tgl   = rsp_tgl_reg;
   assign rsp_x.data      = rsp_reg;
   assign core_reset_hold = lvl2_reg[0];
   assign prog_mode       = lvl2_reg[1];
   assign op_code         = op_reg;
   assign ops_disabled    = (op_reg == jfp_pkg::CMD_NOP_FIRST[7:0]);
   assign prog_addr = mask_addr(addr_reg, jfp_pkg::PROGRAM_ADDR_TOP_BIT);
   assign nv_addr   = mask_addr(addr_reg, jfp_pkg::NV_DATA_ADDR_TOP_BIT);
   assign pb_wr           = pb_wr_reg;
   assign pb_idx          = pb_idx_reg;
   assign pb_wdata        = pb_dat_reg;
   assign fl_rd           = fl_rd_reg;
   assign fl_rd_addr      = fl_adr_reg;

endmodule

// *** test/jfp_chk.sv ***
// Port assertions for the page programming block.
// Assumes rst resets both clock domains asynchronously.
`timescale 1ns/1ps
module jfp_chk (
   // Clocks and reset
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        tck,
   // Test port
   input wire logic        tdo,
   input wire logic [3:0]  instr,
   input wire logic        capture_dr,
   input wire logic        shift_dr,
   // Core side
   input wire logic        prog_mode,
   input wire logic [7:0]  op_code,
   input wire logic        ops_disabled,
   input wire logic [15:0] prog_addr,
   input wire logic [15:0] nv_addr,
   input wire logic        pb_wr,
   input wire logic [7:0]  pb_idx,
   input wire logic        fl_rd,
   input wire logic [15:0] fl_rd_addr
);
   // ****************************************************************
   // Helpers
   // ****************************************************************
   logic [7:0] last_idx_reg, last_idx_next;
   logic [3:0] rd_cnt_reg, rd_cnt_next;
   always_comb begin
      last_idx_next = pb_wr ? pb_idx : last_idx_reg;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) last_idx_reg <= 8'h00;
      else last_idx_reg <= last_idx_next;
   end
   // Saturates at eight: only the lead-in matters
   always_comb begin
      rd_cnt_next = rd_cnt_reg;
      if (capture_dr) rd_cnt_next = 4'h0;
      else if (shift_dr && rd_cnt_reg != 4'h8) rd_cnt_next = rd_cnt_reg + 4'h1;
   end
   always_ff @(posedge tck or posedge rst) begin
      if (rst) rd_cnt_reg <= 4'h0;
      else rd_cnt_reg <= rd_cnt_next;
   end
   // ****************************************************************
   // Properties
   // ****************************************************************
   property p_nv_mask;
      @(posedge clk) disable iff (rst) nv_addr == {4'h0, prog_addr[11:0]};
   endproperty
   a_nv_mask: assert property (p_nv_mask)
      else $error("nv address not masked");
   property p_wr_single;
      @(posedge clk) disable iff (rst) pb_wr |=> !pb_wr;
   endproperty
   a_wr_single: assert property (p_wr_single)
      else $error("buffer write longer than one cycle");
   property p_wr_mode;
      @(posedge clk) disable iff (rst) pb_wr |-> prog_mode;
   endproperty
   a_wr_mode: assert property (p_wr_mode)
      else $error("buffer write outside programming mode");
   property p_idx_step;
      @(posedge clk) disable iff (rst)
         pb_wr && pb_idx != 8'h00 |-> pb_idx == last_idx_reg + 8'h01;
   endproperty
   a_idx_step: assert property (p_idx_step)
      else $error("byte position did not step by one");
   property p_rd_page;
      @(posedge clk) disable iff (rst)
         fl_rd |-> fl_rd_addr[15:7] == prog_addr[15:7];
   endproperty
   a_rd_page: assert property (p_rd_page)
      else $error("flash read outside addressed page");
   property p_rd_single;
      @(posedge clk) disable iff (rst) fl_rd |=> !fl_rd;
   endproperty
   a_rd_single: assert property (p_rd_single)
      else $error("flash read longer than one cycle");
   property p_ops;
      @(posedge clk) disable iff (rst) ops_disabled == (op_code == 8'h00);
   endproperty
   a_ops: assert property (p_ops)
      else $error("disable flag disagrees with operation code");
   property p_op_off;
      @(posedge clk) disable iff (rst)
         !prog_mode ##1 !prog_mode |-> op_code == 8'h00;
   endproperty
   a_op_off: assert property (p_op_off)
      else $error("operation code live outside programming mode");
   property p_read_lead;
      @(posedge tck) disable iff (rst)
         shift_dr && prog_mode && instr == jfp_pkg::PAGE_READ_INSTR
         && rd_cnt_reg < 4'h8 |-> tdo == 1'b0;
   endproperty
   a_read_lead: assert property (p_read_lead)
      else $error("page read lead-in bits not zero");
endmodule

// *** test/jfp_prog_model.sv ***
// Scan-port programmer: gated test clock and data-register scans.
// Assumes its tap strobes go straight to the block.
`timescale 1ns/1ps
module jfp_prog_model (
   // Test port
   output logic       tck,
   output logic       tdi,
   output logic [3:0] instr,
   output logic       capture_dr,
   output logic       shift_dr,
   output logic       update_dr,
   input  wire logic  tdo
);
   logic tck_en;
   // Clock stands low between scans
   initial begin
      {tck_en, tck, tdi, capture_dr, shift_dr, update_dr} = '0;
      instr = 4'h0;
      #7;
      forever #16 tck = tck_en ? ~tck : 1'b0;
   end
   task automatic idle(input logic [3:0] ins, input int n);
      tck_en = 1'b1;
      @(posedge tck) instr <= ins;
      repeat (n) @(posedge tck);
      tck_en = 1'b0;
   endtask
   task automatic dr(input logic [3:0] ins, input int n,
                     input logic [2055:0] din, output logic [2055:0] dout);
      dout = '0;
      tck_en = 1'b1;
      @(posedge tck) begin
         instr <= ins;
         capture_dr <= 1'b1;
      end
      for (int i = 0; i <= n; i++) begin
         @(posedge tck);
         if (i > 0)
            dout[i-1] = tdo;
         capture_dr <= 1'b0;
         shift_dr <= (i < n);
         update_dr <= (i == n);
         tdi <= (i < n) ? din[i] : ~tdi;
      end
      @(posedge tck) update_dr <= 1'b0;
      tck_en = 1'b0;
   endtask
endmodule

// *** test/jtag_flash_page_programming_tb_top.sv ***
// Bench for the page programming block with a programmer model.
// Assumes the flash answers combinationally while its read is high.
`timescale 1ns/1ps
bind jfp_prog_port jfp_chk u_chk (.clk(clk), .rst(rst), .tck(tck),
   .tdo(tdo), .instr(instr), .capture_dr(capture_dr), .shift_dr(shift_dr),
   .prog_mode(prog_mode), .op_code(op_code), .ops_disabled(ops_disabled),
   .prog_addr(prog_addr), .nv_addr(nv_addr), .pb_wr(pb_wr),
   .pb_idx(pb_idx), .fl_rd(fl_rd), .fl_rd_addr(fl_rd_addr));
module jtag_flash_page_programming_tb_top;
   logic          clk, rst, tck, tdi, tdo, capture_dr, shift_dr, update_dr;
   logic [3:0]    instr;
   logic          core_reset_hold, prog_mode, ops_disabled, pb_wr, fl_rd;
   logic [7:0]    op_code, pb_idx, pb_wdata;
   logic [15:0]   prog_addr, nv_addr, fl_rd_addr, fl_rd_data;
   logic [15:0]   wr_q[$];
   logic [2055:0] so;
   int            n_mismatch = 0, checked = 0, cycles = 0;
   jfp_prog_port dut (.clk(clk), .rst(rst), .tck(tck), .tdi(tdi), .tdo(tdo),
      .instr(instr), .capture_dr(capture_dr), .shift_dr(shift_dr),
      .update_dr(update_dr), .core_reset_hold(core_reset_hold),
      .prog_mode(prog_mode), .op_code(op_code), .ops_disabled(ops_disabled),
      .prog_addr(prog_addr), .nv_addr(nv_addr), .pb_wr(pb_wr),
      .pb_idx(pb_idx), .pb_wdata(pb_wdata), .fl_rd(fl_rd),
      .fl_rd_addr(fl_rd_addr), .fl_rd_data(fl_rd_data));
   jfp_prog_model m (.tck(tck), .tdi(tdi), .instr(instr),
      .capture_dr(capture_dr), .shift_dr(shift_dr), .update_dr(update_dr),
      .tdo(tdo));
   // Flash content derived from the word address; inverted when idle
   assign fl_rd_data = fl_rd ? fl_rd_addr ^ 16'h6b29 : ~fl_rd_addr;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (pb_wr === 1'b1)
         wr_q.push_back({pb_idx, pb_wdata});
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      if (n_mismatch == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic settle();
      repeat (8) @(posedge clk);
   endtask
   task automatic cmd(input logic [6:0] c, input logic [7:0] d);
      m.dr(jfp_pkg::PROGRAM_COMMAND_INSTR, jfp_pkg::CMD_W, {c, d}, so);
      settle();
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_enter();
      m.dr(jfp_pkg::CORE_RESET_HOLD_INSTR, 1, 1, so);
      settle();
      chk(core_reset_hold, 1);
      m.dr(jfp_pkg::PAGE_LOAD_INSTR, 8, 8'h5a, so);
      settle();
      chk(wr_q.size(), 0);
      m.dr(jfp_pkg::PROGRAM_MODE_KEY_INSTR, 16, jfp_pkg::MODE_KEY ^ 1, so);
      settle();
      chk(prog_mode, 0);
      m.dr(jfp_pkg::PROGRAM_MODE_KEY_INSTR, 16, jfp_pkg::MODE_KEY, so);
      settle();
      chk(prog_mode, 1);
   endtask
   task automatic t_addr();
      cmd(jfp_pkg::CMD_ADDR_HI, 8'hf5);
      cmd(jfp_pkg::CMD_ADDR_LO, 8'ha6);
      chk(prog_addr, 16'hf5a6);
      chk(nv_addr, 16'h05a6);
   endtask
   task automatic t_load();
      logic [2055:0] d;
      d = '0;
      for (int k = 0; k < 256; k++)
         d[8*k +: 8] = k[7:0] ^ 8'ha5;
      // Three trailing bits make a partial byte that must be dropped
      d[2050:2048] = 3'h7;
      wr_q.delete();
      m.dr(jfp_pkg::PAGE_LOAD_INSTR, 2051, d, so);
      settle();
      chk(wr_q.size(), 256);
      for (int k = 0; k < 256; k++)
         chk(wr_q[k], {k[7:0], k[7:0] ^ 8'ha5});
   endtask
   task automatic t_read();
      m.idle(jfp_pkg::PAGE_READ_INSTR, 10);
      m.dr(jfp_pkg::PAGE_READ_INSTR, 2056, '0, so);
      chk(so[7:0], 0);
      for (int k = 0; k < 128; k++)
         chk(so[8+16*k +: 16], {9'h1eb, k[6:0]} ^ 16'h6b29);
   endtask
   task automatic t_exit();
      cmd(jfp_pkg::CMD_ENTER, 8'h10);
      chk(op_code, 8'h10);
      chk(ops_disabled, 0);
      cmd(jfp_pkg::CMD_NOP_FIRST[14:8], jfp_pkg::CMD_NOP_FIRST[7:0]);
      chk(ops_disabled, 1);
      cmd(jfp_pkg::CMD_NOP_SECOND[14:8], jfp_pkg::CMD_NOP_SECOND[7:0]);
      chk(op_code, 0);
      m.dr(jfp_pkg::PROGRAM_MODE_KEY_INSTR, 16, 0, so);
      settle();
      chk(prog_mode, 0);
      m.dr(jfp_pkg::CORE_RESET_HOLD_INSTR, 1, 0, so);
      settle();
      chk(core_reset_hold, 0);
      cmd(jfp_pkg::CMD_ADDR_LO, 8'h11);
      chk(prog_addr, 16'hf5a6);
   endtask
   initial begin
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({core_reset_hold, prog_mode, pb_wr, fl_rd, op_code, prog_addr}, 0);
      t_enter();
      t_addr();
      t_load();
      t_read();
      t_exit();
      give_verdict();
   end
endmodule
